// ---- core/nrts_host_seq.sv ----
// host-side packet sequencer for the navigation receiver link
`timescale 1ns/100ps
`include "nrts_cfg.svh"
module nrts_host_seq
   import nrts_pkg::*;
#(
   parameter int          CNT_W      = 16,
   parameter longint      RPT_TMO    = `NRTS_RPT_TMO_CYC
) (
   // clock and control
   input  wire logic             clk_sys_i,
   input  wire logic             rst_i,
   input  wire logic             ce_i,
   // user request
   input  wire logic             req_valid_i,
   input  wire nrts_xfer_t       req_kind_i,
   input  wire logic [CNT_W-1:0] req_count_i,
   input  wire logic             rpt_start_i,
   input  wire logic             rpt_stop_i,
   input  wire logic             prod_req_i,
   output logic                  busy_o,
   output logic                  rpt_en_o,
   output logic                  rpt_lost_o,
   // outgoing packets to link layer
   output logic                  tx_valid_o,
   output nrts_pkt_t             tx_pkt_o,
   input  wire logic             tx_ready_i,
   // incoming packets from link layer
   input  wire logic             rx_valid_i,
   input  wire nrts_pkt_t        rx_pkt_i,
   output logic                  rpt_seen_o,
   output logic      [CNT_W-1:0] rx_tracks_o,
   output logic      [CNT_W-1:0] rx_recs_o,
   output logic                  rx_done_o,
   output logic      [15:0]      rx_done_cmd_o
);
   ////////////////////////////////////////////////////////////////////////
   nrts_state_t      st_r, st_nxt;
   nrts_xfer_t       kind_r, kind_nxt;
   logic [CNT_W-1:0] left_r, left_nxt;
   logic [CNT_W-1:0] avail_r, avail_nxt;
   logic             hdr_r, hdr_nxt;
   logic             orb_dt_r, orb_dt_nxt;
   logic             busy_nxt, txv_nxt, en_nxt, seen_nxt, lost_nxt;
   nrts_pkt_t        pkt_nxt;
   logic [31:0]      tmo_r, tmo_nxt;
   logic             send;

   function automatic logic [15:0] done_cmd(input nrts_xfer_t k);
      case (k)
         NRTS_X_TRK: done_cmd = `NRTS_CMD_TRK; // R21
         NRTS_X_PRX: done_cmd = `NRTS_CMD_PRX;
         default:    done_cmd = `NRTS_CMD_ORBIT;
      endcase
   endfunction

   function automatic logic [7:0] body_pid(input nrts_xfer_t k,
                                           input logic hdr);
      if (k == NRTS_X_TRK && hdr) begin
         body_pid = `NRTS_PID_TRK_HDR;
      end else if (k == NRTS_X_TRK) begin
         body_pid = `NRTS_PID_TRK_PT;
      end else if (k == NRTS_X_PRX) begin
         body_pid = `NRTS_PID_PRX_WPT;
      end else begin
         body_pid = `NRTS_PID_ORBIT;
      end
   endfunction

   assign send = ce_i && tx_valid_o && tx_ready_i;

   ////////////////////////////////////////////////////////////////////////
   // transmit sequencing; a packet is offered and held until taken
   always_comb begin
      st_nxt     = st_r;
      kind_nxt   = kind_r;
      left_nxt   = left_r;
      avail_nxt  = avail_r;
      hdr_nxt    = hdr_r;
      orb_dt_nxt = orb_dt_r;
      txv_nxt    = tx_valid_o;
      pkt_nxt    = tx_pkt_o;
      if (send) begin
         txv_nxt = 1'b0;
      end
      case (st_r)
         NRTS_IDLE: begin
            if (!tx_valid_o && orb_dt_r) begin
               orb_dt_nxt = 1'b0;
               pkt_nxt    = '{pid: `NRTS_PID_DATE_TIME, cmd: 16'h0000}; // R10
               txv_nxt    = 1'b1;
               st_nxt     = NRTS_POS;
            end else if (!tx_valid_o && req_valid_i) begin
               kind_nxt = req_kind_i;
               // R8 fixed-order orbit table without satellite id
               left_nxt = (req_kind_i == NRTS_X_ORBIT) ?
                          CNT_W'(`NRTS_ORBIT_SATS) : req_count_i;
               hdr_nxt  = 1'b1;
               avail_nxt = req_count_i;
               txv_nxt  = 1'b1;
               if (req_kind_i == NRTS_X_DT) begin
                  pkt_nxt = '{pid: `NRTS_PID_DATE_TIME, cmd: 16'h0000}; // R12
                  st_nxt  = NRTS_INIT;
               end else if (req_kind_i == NRTS_X_POS) begin
                  pkt_nxt = '{pid: `NRTS_PID_POSITION, cmd: 16'h0000}; // R13
                  st_nxt  = NRTS_INIT;
               end else begin
                  pkt_nxt = '{pid: `NRTS_PID_RECORDS, cmd: 16'h0000}; // R1
                  st_nxt  = NRTS_COUNT;
               end
            end else if (!tx_valid_o && (rpt_start_i || rpt_stop_i
                                          || prod_req_i)) begin
               // report control goes out as a lone packet
               txv_nxt = 1'b1;
               st_nxt  = NRTS_INIT;
               if (rpt_start_i) begin
                  pkt_nxt = '{pid: `NRTS_PID_COMMAND,
                              cmd: `NRTS_CMD_RPT_START}; // R16
               end else if (rpt_stop_i) begin
                  pkt_nxt = '{pid: `NRTS_PID_COMMAND,
                              cmd: `NRTS_CMD_RPT_STOP}; // R16
               end else begin
                  pkt_nxt = '{pid: `NRTS_PID_PRODUCT_REQ,
                              cmd: 16'h0000}; // R17
               end
            end
         end
         NRTS_COUNT, NRTS_BODY: begin
            if (send) begin
               txv_nxt = 1'b1;
               if (left_r == '0) begin
                  pkt_nxt = '{pid: `NRTS_PID_XFER_DONE,
                              cmd: done_cmd(kind_r)}; // R2 R6 R7
                  st_nxt  = NRTS_DONE;
               end else begin
                  // R3 one header then all points; one track per request
                  pkt_nxt  = '{pid: body_pid(kind_r, hdr_r), cmd: 16'h0000};
                  hdr_nxt  = 1'b0;
                  left_nxt = left_r - 1'b1;
                  st_nxt   = NRTS_BODY;
                  // entries past the user's count are absent satellites;
                  // this sequencer writes the negative week into the cmd field
                  if (kind_r == NRTS_X_ORBIT && avail_r == '0) begin
                     pkt_nxt.cmd = `NRTS_WEEK_INVALID; // R9
                  end
                  if (avail_r != '0) begin
                     avail_nxt = avail_r - 1'b1;
                  end
               end
            end
         end
         NRTS_DONE: begin
            if (send) begin
               orb_dt_nxt = (kind_r == NRTS_X_ORBIT); // R10
               st_nxt     = NRTS_IDLE;
            end
         end
         NRTS_POS: begin
            if (send) begin
               pkt_nxt = '{pid: `NRTS_PID_POSITION, cmd: 16'h0000}; // R10
               txv_nxt = 1'b1;
               st_nxt  = NRTS_INIT;
            end
         end
         NRTS_INIT: begin
            if (send) begin
               st_nxt = NRTS_IDLE;
            end
         end
         default: st_nxt = NRTS_IDLE;
      endcase
      busy_nxt = (st_nxt != NRTS_IDLE) || orb_dt_nxt;
   end

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         st_r       <= NRTS_IDLE;
         kind_r     <= NRTS_X_NONE;
         left_r     <= '0;
         avail_r    <= '0;
         hdr_r      <= 1'b0;
         orb_dt_r   <= 1'b0;
         tx_valid_o <= 1'b0;
         tx_pkt_o   <= '0;
         busy_o     <= 1'b0;
      end else if (ce_i) begin
         st_r       <= st_nxt;
         kind_r     <= kind_nxt;
         left_r     <= left_nxt;
         avail_r    <= avail_nxt;
         hdr_r      <= hdr_nxt;
         orb_dt_r   <= orb_dt_nxt;
         tx_valid_o <= txv_nxt;
         tx_pkt_o   <= pkt_nxt;
         busy_o     <= busy_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // report enable tracking and report watchdog
   always_comb begin
      en_nxt   = rpt_en_o;
      seen_nxt = 1'b0;
      lost_nxt = rpt_lost_o;
      tmo_nxt  = tmo_r;
      if (send && tx_pkt_o.pid == `NRTS_PID_COMMAND) begin
         if (tx_pkt_o.cmd == `NRTS_CMD_RPT_START) begin
            en_nxt = 1'b1; // R16
         end else if (tx_pkt_o.cmd == `NRTS_CMD_RPT_STOP) begin
            en_nxt = 1'b0; // R16
         end
      end
      if (send && tx_pkt_o.pid == `NRTS_PID_PRODUCT_REQ) begin
         en_nxt = 1'b0; // R17
      end
      if (rx_valid_i && rx_pkt_i.pid == `NRTS_PID_REPORT) begin
         seen_nxt = 1'b1; // R19 no ack is sent back, R18
         tmo_nxt  = '0;
         lost_nxt = 1'b0;
      end else if (rpt_en_o) begin
         if (64'(tmo_r) >= 64'(RPT_TMO)) begin
            lost_nxt = 1'b1; // R15
         end else begin
            tmo_nxt = tmo_r + 1'b1;
         end
      end else begin
         tmo_nxt = '0;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         rpt_en_o   <= 1'b0;
         rpt_seen_o <= 1'b0;
         rpt_lost_o <= 1'b0;
         tmo_r      <= 32'h0000_0000;
      end else if (ce_i) begin
         rpt_en_o   <= en_nxt;
         rpt_seen_o <= seen_nxt;
         rpt_lost_o <= lost_nxt;
         tmo_r      <= tmo_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // receive-side tallies
   nrts_rx_tracker #(.CNT_W(CNT_W)) u_rx (
      .clk_sys_i  (clk_sys_i),
      .rst_i      (rst_i),
      .ce_i       (ce_i),
      .rx_valid_i (rx_valid_i),
      .rx_pkt_i   (rx_pkt_i),
      .track_cnt_o(rx_tracks_o),
      .rec_cnt_o  (rx_recs_o),
      .done_o     (rx_done_o),
      .done_cmd_o (rx_done_cmd_o)
   );

   sequence s_orbit_end;
      send && st_r == NRTS_DONE && kind_r == NRTS_X_ORBIT;
   endsequence

   orbit_then_dt_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      ce_i throughout s_orbit_end ##1 ce_i
      |=> tx_valid_o && tx_pkt_o.pid == `NRTS_PID_DATE_TIME) // R10
      else $error("date-time not sent after orbit table");
   done_cmd_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      tx_valid_o && tx_pkt_o.pid == `NRTS_PID_XFER_DONE && kind_r == NRTS_X_TRK
      |-> tx_pkt_o.cmd == `NRTS_CMD_TRK) // R2
      else $error("track completion carries wrong command");
   first_hdr_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      ce_i && send && st_r == NRTS_COUNT && kind_r == NRTS_X_TRK
      && left_r != '0 |=> tx_pkt_o.pid == `NRTS_PID_TRK_HDR) // R1
      else $error("track header not after record count");
   orbit_count_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      ce_i && st_r == NRTS_IDLE && !tx_valid_o && !orb_dt_r && req_valid_i
      && req_kind_i == NRTS_X_ORBIT
      |=> left_r == CNT_W'(`NRTS_ORBIT_SATS)) // R8
      else $error("orbit table not 32 entries");
   start_en_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      send && tx_pkt_o.pid == `NRTS_PID_COMMAND
      && tx_pkt_o.cmd == `NRTS_CMD_RPT_START |=> rpt_en_o) // R16
      else $error("report start did not enable");
   prod_off_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      send && tx_pkt_o.pid == `NRTS_PID_PRODUCT_REQ |=> !rpt_en_o) // R17
      else $error("product request left reports enabled");
   init_single_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      send && st_r == NRTS_INIT ##1 ce_i |=> !tx_valid_o || orb_dt_r
      || tx_pkt_o.pid != `NRTS_PID_XFER_DONE) // R12
      else $error("init exchange followed by completion");
endmodule

// ---- core/nrts_cfg.svh ----
// constants for the navigation record transfer host sequencer
// Functional notes
// [R1] track log: record count, header, points, then transfer complete
// [R2] track completion carries the track transfer command identifier
// [R3] several tracks follow back to back, one completion after the last (the host sends one header and one track per request)
// [R4] receiver treats every track header identifier as a new track log
// [R5] device sends all proximity waypoints; host may send any subset
// [R6] proximity: count, waypoint packets, completion with proximity command
// [R7] orbit table: count, one packet per satellite, completion with orbit command
// [R8] orbit records without satellite id: exactly 32, in satellite order
// [R9] missing satellite entries carry a negative week number
// [R10] after orbit table load, host sends date-time then position
// [R11] device may request time or position after receiving orbit table
// [R12] date-time init is one packet, no count, no completion
// [R13] position init is one packet, no count, no completion
// [R14] device may discard init position when it has fix or simulates
// [R15] device sends one report about every second while enabled
// [R16] start command enables reports, stop command disables them
// [R17] product data answer disables reports; host re-enables afterwards (rpt_en_o stays low until the next start command)
// [R18] report acknowledgement optional; negative ack causes no retransmit
// [R19] each report is one packet from device to host
// [R20] multibyte fields go least significant byte first, no padding
// [R21] packet and command identifiers are configurable constants
`ifndef NRTS_CFG_SVH
`define NRTS_CFG_SVH
`define NRTS_PID_RECORDS     8'h1B
`define NRTS_PID_XFER_DONE   8'h0C
`define NRTS_PID_TRK_HDR     8'h63
`define NRTS_PID_TRK_PT      8'h22
`define NRTS_PID_PRX_WPT     8'h13
`define NRTS_PID_ORBIT       8'h1F
`define NRTS_PID_DATE_TIME   8'h0E
`define NRTS_PID_POSITION    8'h11
`define NRTS_PID_REPORT      8'h33
`define NRTS_PID_COMMAND     8'h0A
`define NRTS_PID_PRODUCT_REQ 8'hFE
`define NRTS_CMD_TRK         16'h0006
`define NRTS_CMD_PRX         16'h0003
`define NRTS_CMD_ORBIT       16'h0001
`define NRTS_CMD_RPT_START   16'h0031
`define NRTS_CMD_RPT_STOP    16'h0032
`define NRTS_ORBIT_SATS      6'h20
`define NRTS_WEEK_INVALID    16'hFFFF
`define NRTS_CLK_MHZ         125
`define NRTS_RPT_PERIOD_MS   1000
`define NRTS_RPT_TMO_CYC     ((`NRTS_RPT_PERIOD_MS * 2) * (`NRTS_CLK_MHZ * 1000))
`endif

// ---- core/nrts_pkg.sv ----
// types for the navigation record transfer host sequencer
package nrts_pkg;
   typedef struct packed {
      logic [7:0]  pid;
      logic [15:0] cmd;
   } nrts_pkt_t;
   typedef enum logic [2:0] {
      NRTS_IDLE  = 3'b000,
      NRTS_COUNT = 3'b001,
      NRTS_BODY  = 3'b011,
      NRTS_DONE  = 3'b010,
      NRTS_INIT  = 3'b110,
      NRTS_POS   = 3'b111
   } nrts_state_t;
   typedef enum logic [2:0] {
      NRTS_X_TRK   = 3'd0,
      NRTS_X_PRX   = 3'd1,
      NRTS_X_ORBIT = 3'd2,
      NRTS_X_DT    = 3'd3,
      NRTS_X_POS   = 3'd4,
      NRTS_X_NONE  = 3'd7
   } nrts_xfer_t;
endpackage

// ---- core/nrts_rx_tracker.sv ----
// receive-side tracker: counts tracks and records in incoming transfers
`timescale 1ns/100ps
`include "nrts_cfg.svh"
module nrts_rx_tracker
   import nrts_pkg::*;
#(
   parameter int CNT_W = 16
) (
   // clock and reset
   input  wire logic             clk_sys_i,
   input  wire logic             rst_i,
   input  wire logic             ce_i,
   // incoming packets
   input  wire logic             rx_valid_i,
   input  wire nrts_pkt_t        rx_pkt_i,
   // tallies
   output logic      [CNT_W-1:0] track_cnt_o,
   output logic      [CNT_W-1:0] rec_cnt_o,
   output logic                  done_o,
   output logic      [15:0]      done_cmd_o
);
   logic [CNT_W-1:0] trk_nxt, rec_nxt;
   logic             done_nxt;
   logic [15:0]      cmd_nxt;

   always_comb begin
      trk_nxt  = track_cnt_o;
      rec_nxt  = rec_cnt_o;
      done_nxt = 1'b0;
      cmd_nxt  = done_cmd_o;
      if (rx_valid_i) begin
         if (rx_pkt_i.pid == `NRTS_PID_RECORDS) begin
            trk_nxt = '0;
            rec_nxt = '0;
         end else if (rx_pkt_i.pid == `NRTS_PID_TRK_HDR) begin
            trk_nxt = track_cnt_o + 1'b1; // R4
         end else if (rx_pkt_i.pid == `NRTS_PID_XFER_DONE) begin
            done_nxt = 1'b1;
            cmd_nxt  = rx_pkt_i.cmd;
         end else if (rx_pkt_i.pid != `NRTS_PID_REPORT) begin
            rec_nxt = rec_cnt_o + 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         track_cnt_o <= '0;
         rec_cnt_o   <= '0;
         done_o      <= 1'b0;
         done_cmd_o  <= 16'h0000;
      end else if (ce_i) begin
         track_cnt_o <= trk_nxt;
         rec_cnt_o   <= rec_nxt;
         done_o      <= done_nxt;
         done_cmd_o  <= cmd_nxt;
      end
   end

   a_trk_count_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      ce_i && rx_valid_i && rx_pkt_i.pid == `NRTS_PID_TRK_HDR
      |=> track_cnt_o == $past(track_cnt_o) + 1'b1) // R4
      else $error("track header not counted");
endmodule

// ---- sim/nrts_dev_model.sv ----
// device-side model of the navigation receiver for the host sequencer bench
`timescale 1ns/100ps
`include "nrts_cfg.svh"
module nrts_dev_model
   import nrts_pkg::*;
#(
   parameter int PERIOD = 50
) (
   // clock and reset
   input  wire logic      clk_sys_i,
   input  wire logic      rst_i,
   // packets from host
   input  wire logic      tx_valid_i,
   input  wire nrts_pkt_t tx_pkt_i,
   output logic           tx_ready_o,
   // packets to host
   output logic           rx_valid_o,
   output nrts_pkt_t      rx_pkt_o
);
   nrts_pkt_t log_q[$];
   logic      slow = 1'b0;
   logic      rpt_on = 1'b0;
   logic      mute = 1'b0;
   int        tick = 0;

   initial begin
      tx_ready_o = 1'b0;
      rx_valid_o = 1'b0;
      rx_pkt_o   = '0;
   end

   ////////////////////////////////////////////////////////////////////////
   // one packet to the host; afterwards the lines show the inverse value
   task automatic send(input logic [7:0] p, input logic [15:0] c);
      @(posedge clk_sys_i);
      rx_valid_o <= 1'b1;
      rx_pkt_o   <= '{p, c};
      @(posedge clk_sys_i);
      rx_valid_o <= 1'b0;
      rx_pkt_o   <= ~rx_pkt_o;
   endtask

   ////////////////////////////////////////////////////////////////////////
   // accept host packets, stalling every other cycle when slow
   always @(posedge clk_sys_i) begin
      if (tx_valid_i && tx_ready_o && !rst_i) begin
         // keeps every packet; sends no time or position request
         log_q.push_back(tx_pkt_i);
         if (tx_pkt_i.pid == `NRTS_PID_COMMAND &&
             tx_pkt_i.cmd == `NRTS_CMD_RPT_START)
            rpt_on <= 1'b1;
         if ((tx_pkt_i.pid == `NRTS_PID_COMMAND &&
              tx_pkt_i.cmd == `NRTS_CMD_RPT_STOP) ||
             tx_pkt_i.pid == `NRTS_PID_PRODUCT_REQ)
            rpt_on <= 1'b0;
      end
      tx_ready_o <= slow ? ~tx_ready_o : 1'b1;
   end

   // one single-packet report a period while enabled, never resent
   always @(posedge clk_sys_i) begin
      tick <= (rpt_on && tick < PERIOD) ? tick + 1 : 0;
      if (rpt_on && !mute && tick == PERIOD)
         send(`NRTS_PID_REPORT, 16'h0000);
   end
endmodule

// ---- sim/test_nrts_host_seq.sv ----
// self-checking bench for the host sequencer
`timescale 1ns/100ps
`include "nrts_cfg.svh"
module test_nrts_host_seq;
   import nrts_pkg::*;
   logic        clk_sys_i;
   logic        rst_i;
   logic        req_valid_i;
   nrts_xfer_t  req_kind_i;
   logic [15:0] req_count_i;
   logic        busy_o;
   logic        rpt_en_o;
   logic        rpt_lost_o;
   logic        rpt_start;
   logic        rpt_stop;
   logic        prod_req;
   logic        tx_valid_o;
   nrts_pkt_t   tx_pkt_o;
   logic        tx_ready;
   logic        rx_valid;
   nrts_pkt_t   rx_pkt;
   logic        rpt_seen_o;
   logic [15:0] rx_tracks_o;
   logic [15:0] rx_recs_o;
   logic        rx_done_o;
   logic [15:0] rx_done_cmd_o;
   nrts_pkt_t   exp_q[$];
   int          failures = 0;
   int          n_compared = 0;
   int          n_done = 0;
   int          n_seen = 0;

   nrts_host_seq #(.RPT_TMO(100)) dut_u (
      .clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(1'b1),
      .req_valid_i(req_valid_i), .req_kind_i(req_kind_i),
      .req_count_i(req_count_i), .rpt_start_i(rpt_start),
      .rpt_stop_i(rpt_stop), .prod_req_i(prod_req), .busy_o(busy_o),
      .rpt_en_o(rpt_en_o),
      .rpt_lost_o(rpt_lost_o), .tx_valid_o(tx_valid_o),
      .tx_pkt_o(tx_pkt_o), .tx_ready_i(tx_ready), .rx_valid_i(rx_valid),
      .rx_pkt_i(rx_pkt), .rpt_seen_o(rpt_seen_o),
      .rx_tracks_o(rx_tracks_o), .rx_recs_o(rx_recs_o),
      .rx_done_o(rx_done_o), .rx_done_cmd_o(rx_done_cmd_o));

   nrts_dev_model dev_u (
      .clk_sys_i(clk_sys_i), .rst_i(rst_i), .tx_valid_i(tx_valid_o),
      .tx_pkt_i(tx_pkt_o), .tx_ready_o(tx_ready), .rx_valid_o(rx_valid),
      .rx_pkt_o(rx_pkt));

   initial begin
      clk_sys_i = 1'b0;
      forever #4 clk_sys_i = ~clk_sys_i;
   end

   // one-cycle pulses counted at the edge that ends them
   always @(posedge clk_sys_i) begin
      if (rx_done_o === 1'b1)
         n_done++;
      if (rpt_seen_o === 1'b1)
         n_seen++;
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic results();
      $display("compared %0d, mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [23:0] e,
                      input logic [23:0] g);
      n_compared++;
      if (g !== e) begin
         failures++;
         $display("unexpected %s: expected %h, seen %h", nm, e, g);
      end
   endtask

   task automatic push(input logic [7:0] p, input logic [15:0] c);
      exp_q.push_back('{p, c});
   endtask

   // issue one request, wait for the sequence to drain, compare the log
   task automatic run_xfer(input nrts_xfer_t k, input logic [15:0] n);
      int i;
      dev_u.log_q.delete();
      @(posedge clk_sys_i);
      req_valid_i <= 1'b1;
      req_kind_i  <= k;
      req_count_i <= n;
      @(posedge clk_sys_i);
      req_valid_i <= 1'b0;
      i = 0;
      #1;
      while (i < 400 && (busy_o !== 1'b0 || tx_valid_o !== 1'b0)) begin
         @(posedge clk_sys_i);
         #1;
         i++;
      end
      if (i == 400) begin
         failures++;
         results();
      end else begin
         repeat (2) @(posedge clk_sys_i);
         chk("packet total", 24'(exp_q.size()), 24'(dev_u.log_q.size()));
         foreach (exp_q[j])
            if (j < dev_u.log_q.size()) begin
               chk("packet id", 24'(exp_q[j].pid), 24'(dev_u.log_q[j].pid));
               chk("packet command", 24'(exp_q[j].cmd),
                   24'(dev_u.log_q[j].cmd));
            end
         exp_q.delete();
      end
   endtask

   ////////////////////////////////////////////////////////////////////////
   task automatic t_track();
      dev_u.slow = 1'b1;
      push(`NRTS_PID_RECORDS, 16'h0000);
      push(`NRTS_PID_TRK_HDR, 16'h0000);
      repeat (2) push(`NRTS_PID_TRK_PT, 16'h0000);
      push(`NRTS_PID_XFER_DONE, `NRTS_CMD_TRK);
      run_xfer(NRTS_X_TRK, 16'h0003);
   endtask

   task automatic t_prx();
      dev_u.slow = 1'b0;
      push(`NRTS_PID_RECORDS, 16'h0000);
      repeat (2) push(`NRTS_PID_PRX_WPT, 16'h0000);
      push(`NRTS_PID_XFER_DONE, `NRTS_CMD_PRX);
      run_xfer(NRTS_X_PRX, 16'h0002);
   endtask

   // a short count must still yield the full fixed table
   task automatic t_orbit();
      dev_u.slow = 1'b1;
      push(`NRTS_PID_RECORDS, 16'h0000);
      repeat (5) push(`NRTS_PID_ORBIT, 16'h0000);
      repeat (27) push(`NRTS_PID_ORBIT, `NRTS_WEEK_INVALID);
      push(`NRTS_PID_XFER_DONE, `NRTS_CMD_ORBIT);
      push(`NRTS_PID_DATE_TIME, 16'h0000);
      push(`NRTS_PID_POSITION, 16'h0000);
      run_xfer(NRTS_X_ORBIT, 16'h0005);
   endtask

   task automatic t_init();
      dev_u.slow = 1'b0;
      push(`NRTS_PID_DATE_TIME, 16'h0000);
      run_xfer(NRTS_X_DT, 16'h0004);
      push(`NRTS_PID_POSITION, 16'h0000);
      run_xfer(NRTS_X_POS, 16'h0004);
   endtask

   // two tracks back to back, one completion, then one report
   task automatic t_rx();
      dev_u.send(`NRTS_PID_RECORDS, 16'h0005);
      dev_u.send(`NRTS_PID_TRK_HDR, 16'h0000);
      dev_u.send(`NRTS_PID_TRK_PT, 16'h0000);
      dev_u.send(`NRTS_PID_TRK_HDR, 16'h0000);
      dev_u.send(`NRTS_PID_TRK_PT, 16'h0000);
      dev_u.send(`NRTS_PID_TRK_PT, 16'h0000);
      dev_u.send(`NRTS_PID_XFER_DONE, `NRTS_CMD_TRK);
      dev_u.send(`NRTS_PID_REPORT, 16'h0000);
      repeat (4) @(posedge clk_sys_i);
      chk("tracks", 24'(rx_tracks_o), 24'h00_0002);
      chk("records", 24'(rx_recs_o), 24'h00_0003);
      chk("done pulses", 24'(n_done), 24'h00_0001);
      chk("done command", 24'(rx_done_cmd_o), 24'(`NRTS_CMD_TRK));
      chk("report pulses", 24'(n_seen), 24'h00_0001);
      chk("reports enabled", 24'(rpt_en_o), 24'h00_0000);
   endtask

   // pulse report-control inputs for one request edge
   task automatic cmd_pulse(input logic [2:0] m);
      @(posedge clk_sys_i);
      {prod_req, rpt_stop, rpt_start} <= m;
      @(posedge clk_sys_i);
      {prod_req, rpt_stop, rpt_start} <= 3'h0;
   endtask

   // start, stop, silent device, product request
   task automatic t_rpt();
      int s0;
      dev_u.log_q.delete();
      s0 = n_seen;
      cmd_pulse(3'h1);
      repeat (200) @(posedge clk_sys_i);
      #1;
      chk("reports enabled", 24'(rpt_en_o), 24'h00_0001);
      chk("report lost", 24'(rpt_lost_o), 24'h00_0000);
      chk("three reports", 24'(n_seen - s0 >= 3), 24'h00_0001);
      cmd_pulse(3'h2);
      repeat (60) @(posedge clk_sys_i);
      #1;
      chk("reports enabled", 24'(rpt_en_o), 24'h00_0000);
      dev_u.mute = 1'b1;
      cmd_pulse(3'h1);
      repeat (150) @(posedge clk_sys_i);
      #1;
      chk("report lost", 24'(rpt_lost_o), 24'h00_0001);
      cmd_pulse(3'h4);
      repeat (4) @(posedge clk_sys_i);
      #1;
      chk("reports enabled", 24'(rpt_en_o), 24'h00_0000);
      chk("start command", 24'(dev_u.log_q[0]),
          {`NRTS_PID_COMMAND, `NRTS_CMD_RPT_START});
      chk("stop command", 24'(dev_u.log_q[1]),
          {`NRTS_PID_COMMAND, `NRTS_CMD_RPT_STOP});
      chk("product request", 24'(dev_u.log_q[3].pid),
          24'(`NRTS_PID_PRODUCT_REQ));
      dev_u.mute = 1'b0;
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      rst_i       = 1'b1;
      req_valid_i = 1'b0;
      req_kind_i  = NRTS_X_NONE;
      req_count_i = 16'h0000;
      {prod_req, rpt_stop, rpt_start} = 3'h0;
      repeat (8) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      @(posedge clk_sys_i);
      #1;
      chk("busy after reset", 24'(busy_o), 24'h00_0000);
      chk("valid after reset", 24'(tx_valid_o), 24'h00_0000);
      t_track();
      t_prx();
      t_orbit();
      t_init();
      t_rx();
      t_rpt();
      results();
   end
endmodule
